// file: design/eep_cfg.svh
// Constants of the serial EEPROM link, both ends
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH
`define EEP_DEV_TYPE 4'ha
`define EEP_ADDR_W 13
`define EEP_PAGE_W 5
`define EEP_PAGE_BYTES 32
`define EEP_MEM_BYTES 8192
`define EEP_ERASED 8'hff
`define EEP_BYTE_BITS 4'h8
`define EEP_CLK_NS 10
`define EEP_TW_NS 1000000
`define EEP_TW_W 24
`define EEP_SCL_QTR 5'h18
`define EEP_FIFO_DEPTH 16
`endif

// file: design/eep_pkg.sv
// Types shared by the EEPROM device end and the bus master end
`include "eep_cfg.svh"
package eep_pkg;
	typedef logic [7:0] eep_byte_t;
	typedef logic [15:0] eep_addr_t;
	typedef logic [`EEP_ADDR_W-1:0] eep_maddr_t;
	typedef enum logic [5:0] {
		D_IDLE = 6'h01, D_RX = 6'h02, D_RACK = 6'h04, D_TX = 6'h08, D_MACK = 6'h10, D_BUSY = 6'h20
	} eep_dst_t;
	typedef enum logic [3:0] {K_SEL = 4'h1, K_AHI = 4'h2, K_ALO = 4'h4, K_DAT = 4'h8} eep_kind_t;
	typedef enum logic [3:0] {H_IDLE = 4'h1, H_START = 4'h2, H_BYTE = 4'h4, H_STOP = 4'h8} eep_hst_t;
	typedef enum logic [5:0] {
		P_SELW = 6'h01, P_AHI = 6'h02, P_ALO = 6'h04, P_WDAT = 6'h08, P_SELR = 6'h10, P_RDAT = 6'h20
	} eep_ph_t;
	typedef struct packed {
		logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, wp_s1, wp_s2;
		logic [2:0] cs_s1, cs_s2;
		eep_dst_t st;
		eep_kind_t kind;
		logic [3:0] cnt;
		eep_byte_t sh;
		logic rw, ack, slot10, sda_oe;
		eep_maddr_t addr;
		logic [`EEP_PAGE_W-1:0] off, cidx;
		logic [`EEP_PAGE_BYTES-1:0] pvalid;
		logic [`EEP_TW_W-1:0] tw_cnt;
	} eep_dev_st_t;
	typedef struct packed {
		logic sda_s1, sda_s2;
		eep_hst_t st;
		eep_ph_t ph;
		logic [1:0] q;
		logic [4:0] tick;
		logic [3:0] bitn;
		eep_byte_t sh;
		logic [7:0] cnt;
		logic scl, sda_oe, ak, poll, rd, cur, rd_valid, done, nack;
		logic [2:0] dev;
		eep_addr_t addr;
		eep_byte_t rd_data;
	} eep_host_st_t;
endpackage : eep_pkg

// file: design/eep_link_if.sv
// Two-wire link between the bus master end and the EEPROM end
interface eep_link_if;
	logic scl;
	logic sda_h_out;
	logic sda_h_oe;
	logic sda_d_out;
	logic sda_d_oe;
	wire sda;
	// Open drain: a driver that is enabled and outputs zero pulls low
	assign sda = ~((sda_h_oe & ~sda_h_out) | (sda_d_oe & ~sda_d_out));
	modport host (output scl, output sda_h_out, output sda_h_oe, input sda);
	modport dev (input scl, input sda, output sda_d_out, output sda_d_oe);
endinterface : eep_link_if

// file: design/eep_host.sv
// Bus master end: write data FIFO and the byte sequencer driving the link
`include "eep_cfg.svh"
module eep_fifo #(
	parameter int W = 8,
	parameter int DEPTH = `EEP_FIFO_DEPTH
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Async reset
	input wire logic [W-1:0] in_data, // Word to store
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room for a word
	output logic [W-1:0] out_data, // Oldest word
	output logic out_valid, // Word available
	input wire logic out_ready // Oldest word taken
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} eep_fifo_st_t;
	eep_fifo_st_t r, n;
	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW:0] lvl;
	// Extra pointer bit tells full from empty
	assign lvl = r.wp - r.rp;
	assign in_ready = lvl != (AW+1)'(DEPTH);
	assign out_valid = lvl != '0;
	assign out_data = mem[r.rp[AW-1:0]];
	always_comb begin
		n = r;
		if (in_valid && in_ready) n.wp = r.wp + 1'b1;
		if (out_valid && out_ready) n.rp = r.rp + 1'b1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) r <= '0;
		else r <= n;
	end
	// Storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) mem[r.wp[AW-1:0]] <= in_data;
	end
endmodule : eep_fifo

module eep_host (
	input wire logic clk, // Core clock 100 MHz
	input wire logic rst_n, // Async reset
	eep_link_if.host link, // Two-wire link
	input wire logic cmd_valid, // Command offered
	output logic cmd_ready, // Sequencer idle
	input wire logic cmd_read, // 1 read, 0 write unless cmd_cur is set
	input wire logic cmd_cur, // With cmd_read, read from current address; alone, read from cmd_addr
	input wire logic [2:0] cmd_dev, // Target strap code
	input wire eep_pkg::eep_addr_t cmd_addr, // Byte address
	input wire logic [7:0] cmd_len, // Byte count, 1 or more
	input wire eep_pkg::eep_byte_t wr_data, // Write byte
	input wire logic wr_valid, // Write byte offered
	output logic wr_ready, // FIFO has room
	output eep_pkg::eep_byte_t rd_data, // Read byte
	output logic rd_valid, // Read byte pulse
	output logic done, // Command finished pulse
	output logic data_nack // Last command saw a refused write byte; any new command clears it
);
	import eep_pkg::*;
	eep_host_st_t r, n;
	eep_byte_t f_data;
	logic f_valid, f_pop, tick_en, rx, last;
	eep_byte_t ld;
	eep_fifo #(.W(8), .DEPTH(`EEP_FIFO_DEPTH)) u_eep_fifo (
		.clk(clk), .rst_n(rst_n), .in_data(wr_data), .in_valid(wr_valid), .in_ready(wr_ready),
		.out_data(f_data), .out_valid(f_valid), .out_ready(f_pop)
	);
	assign tick_en = r.tick == `EEP_SCL_QTR;
	assign rx = r.ph == P_RDAT;
	assign last = r.cnt == 8'h01;
	// Byte to send, picked by phase; both selects carry the same upper seven bits
	always_comb begin
		case (r.ph)
			P_SELW: ld = {`EEP_DEV_TYPE, r.dev, 1'b0};
			P_AHI: ld = r.addr[15:8];
			P_ALO: ld = r.addr[7:0];
			P_WDAT: ld = f_data;
			P_SELR: ld = {`EEP_DEV_TYPE, r.dev, 1'b1};
			default: ld = 8'h00;
		endcase
	end
	// Sequencer: four quarter ticks per bit, SCL high in the middle two
	always_comb begin
		n = r;
		f_pop = 1'b0;
		n.sda_s1 = link.sda;
		n.sda_s2 = r.sda_s1;
		n.rd_valid = 1'b0;
		n.done = 1'b0;
		n.tick = tick_en ? 5'h00 : r.tick + 5'h01;
		case (r.st)
			H_IDLE: begin
				n.scl = 1'b1;
				n.sda_oe = 1'b0;
				n.q = 2'h0;
				if (cmd_valid) begin
					n.rd = cmd_read | cmd_cur;
					n.cur = cmd_read & cmd_cur;
					n.dev = cmd_dev;
					n.addr = cmd_addr;
					n.cnt = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
					n.ph = (cmd_read & cmd_cur) ? P_SELR : P_SELW;
					n.nack = 1'b0;
					n.st = H_START;
				end
			end
			H_START: if (tick_en) begin
				n.q = r.q + 2'h1;
				case (r.q)
					2'h0: n.sda_oe = 1'b0;
					2'h1: n.scl = 1'b1;
					2'h2: n.sda_oe = 1'b1;
					default: begin
						n.scl = 1'b0;
						n.bitn = 4'h0;
						n.st = H_BYTE;
					end
				endcase
			end
			H_STOP: if (tick_en) begin
				n.q = r.q + 2'h1;
				case (r.q)
					2'h0: n.sda_oe = 1'b1;
					2'h1: n.scl = 1'b1;
					2'h2: n.sda_oe = 1'b0;
					default: begin
						n.poll = 1'b0;
						// Busy device refused the select: start over
						if (r.poll) begin
							n.ph = r.cur ? P_SELR : P_SELW;
							n.st = H_START;
						end else begin
							n.done = 1'b1;
							n.st = H_IDLE;
						end
					end
				endcase
			end
			H_BYTE: if (tick_en) begin
				case (r.q)
					2'h0: begin
						// Empty FIFO stalls the bus with SCL low
						if (!(r.bitn == 4'h0 && r.ph == P_WDAT && !f_valid)) n.q = 2'h1;
						if (r.bitn == 4'h0 && !rx) begin
							n.sh = ld;
							f_pop = r.ph == P_WDAT && f_valid;
						end
						if (r.bitn == `EEP_BYTE_BITS) n.sda_oe = rx & ~last;
						else if (rx) n.sda_oe = 1'b0;
						else n.sda_oe = (r.bitn == 4'h0) ? ~ld[7] : ~r.sh[7];
					end
					2'h1: begin
						n.scl = 1'b1;
						n.q = 2'h2;
					end
					2'h2: begin
						n.q = 2'h3;
						if (r.bitn == `EEP_BYTE_BITS) n.ak = ~r.sda_s2;
						else if (rx) n.sh = {r.sh[6:0], r.sda_s2};
					end
					default: begin
						n.scl = 1'b0;
						n.q = 2'h0;
						n.bitn = r.bitn + 4'h1;
						if (r.bitn != `EEP_BYTE_BITS) begin
							if (!rx) n.sh = {r.sh[6:0], 1'b0};
						end else begin
							n.bitn = 4'h0;
							case (r.ph)
								P_SELW: if (r.ak) n.ph = P_AHI;
								else begin
									n.poll = 1'b1;
									n.st = H_STOP;
								end
								P_AHI: n.ph = P_ALO;
								P_ALO: if (r.rd) begin
									n.ph = P_SELR;
									n.st = H_START;
								end else n.ph = P_WDAT;
								P_WDAT: begin
									if (!r.ak) n.nack = 1'b1;
									n.cnt = r.cnt - 8'h01;
									if (last) n.st = H_STOP;
								end
								P_SELR: if (r.ak) n.ph = P_RDAT;
								else begin
									n.poll = 1'b1;
									n.st = H_STOP;
								end
								default: begin
									n.rd_data = r.sh;
									n.rd_valid = 1'b1;
									n.cnt = r.cnt - 8'h01;
									if (last) n.st = H_STOP;
								end
							endcase
						end
					end
				endcase
			end
			default: n.st = H_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= H_IDLE;
			r.ph <= P_SELW;
			r.scl <= 1'b1;
			r.sda_s1 <= 1'b1;
			r.sda_s2 <= 1'b1;
		end else r <= n;
	end
	assign link.scl = r.scl;
	assign link.sda_h_out = 1'b0;
	assign link.sda_h_oe = r.sda_oe;
	assign cmd_ready = r.st == H_IDLE;
	assign rd_data = r.rd_data;
	assign rd_valid = r.rd_valid;
	assign done = r.done;
	assign data_nack = r.nack;
endmodule : eep_host

// file: design/eep_dev.sv
// Serial EEPROM device end: link slave, page latch, write cycle and array
`include "eep_cfg.svh"
module eep_dev #(
	parameter int unsigned INTERNAL_WRITE_TIME_NS = `EEP_TW_NS // Write cycle length
) (
	input wire logic clk, // Core clock 100 MHz
	input wire logic rst_n, // Async reset
	eep_link_if.dev link, // Two-wire link
	input wire logic write_protect_in, // High inhibits writes
	input wire logic [2:0] chip_select_strap_pins, // Strap code to match
	output logic write_busy // Internal write cycle running
);
	import eep_pkg::*;
	// Cycle count rounds up; the commit walk needs at least one page of cycles
	localparam int WCYC_RAW = (INTERNAL_WRITE_TIME_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS;
	localparam int WCYC = (WCYC_RAW < `EEP_PAGE_BYTES) ? `EEP_PAGE_BYTES : WCYC_RAW;
	localparam logic [`EEP_PAGE_W-1:0] PAGE_LAST = `EEP_PAGE_W'(`EEP_PAGE_BYTES - 1);

	eep_dev_st_t r, n;
	eep_byte_t mem [0:`EEP_MEM_BYTES-1] = '{default: `EEP_ERASED};
	eep_byte_t pb [0:`EEP_PAGE_BYTES-1];
	logic scl_rise, scl_fall, start_c, stop_c, sel_ok;
	logic pb_we, mem_we;
	eep_maddr_t mem_wa;
	eep_byte_t rd_byte;

	// Edge and condition detect on the second sync stage only
	assign scl_rise = r.scl_s2 & ~r.scl_d;
	assign scl_fall = ~r.scl_s2 & r.scl_d;
	assign start_c = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
	assign stop_c = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
	assign sel_ok = r.sh[7:4] == `EEP_DEV_TYPE && r.sh[3:1] == r.cs_s2;
	assign rd_byte = mem[r.addr];
	// Commit target keeps the row bits, walks the page offset
	assign mem_wa = {r.addr[`EEP_ADDR_W-1:`EEP_PAGE_W], r.cidx};

	always_comb begin
		n = r;
		pb_we = 1'b0;
		mem_we = 1'b0;
		n.scl_s1 = link.scl;
		n.scl_s2 = r.scl_s1;
		n.scl_d = r.scl_s2;
		n.sda_s1 = link.sda;
		n.sda_s2 = r.sda_s1;
		n.sda_d = r.sda_s2;
		n.wp_s1 = write_protect_in;
		n.wp_s2 = r.wp_s1;
		n.cs_s1 = chip_select_strap_pins;
		n.cs_s2 = r.cs_s1;
		case (r.st)
			// Write cycle: link ignored, one latched byte per cycle goes to the array
			D_BUSY: begin
				n.sda_oe = 1'b0;
				mem_we = r.pvalid[r.cidx];
				n.cidx = r.cidx + 1'b1;
				n.tw_cnt = r.tw_cnt - 1'b1;
				if (r.tw_cnt == `EEP_TW_W'(1)) begin
					n.pvalid = '0;
					n.st = D_IDLE;
				end
			end
			default: begin
				if (start_c) begin
					n.st = D_RX;
					n.kind = K_SEL;
					n.cnt = 4'h0;
					n.sda_oe = 1'b0;
					n.slot10 = 1'b0;
				end else if (stop_c) begin
					n.sda_oe = 1'b0;
					n.st = D_IDLE;
					n.slot10 = 1'b0;
					// Only a stop right after a data ack launches the write
					if (r.slot10 && (|r.pvalid)) begin
						n.st = D_BUSY;
						n.tw_cnt = `EEP_TW_W'(WCYC);
						n.cidx = '0;
						n.addr = {r.addr[`EEP_ADDR_W-1:`EEP_PAGE_W], r.off};
					end else n.pvalid = '0;
				end else begin
					case (r.st)
						D_RX: begin
							if (scl_rise) begin
								n.sh = {r.sh[6:0], r.sda_s2};
								n.cnt = r.cnt + 4'h1;
							end
							// Tenth slot closes on its fall, so a stop in its high phase still launches the write
							if (scl_fall) n.slot10 = 1'b0;
							// Byte complete: decide the answer before the ninth clock
							if (scl_fall && r.cnt == `EEP_BYTE_BITS) begin
								n.st = D_RACK;
								n.ack = 1'b1;
								case (r.kind)
									K_SEL: begin
										n.ack = sel_ok;
										n.rw = r.sh[0];
										n.pvalid = '0;
									end
									K_AHI: n.addr[`EEP_ADDR_W-1:8] = r.sh[`EEP_ADDR_W-9:0];
									K_ALO: begin
										n.addr[7:0] = r.sh;
										n.off = r.sh[`EEP_PAGE_W-1:0];
									end
									default: begin
										n.ack = ~r.wp_s2;
										if (!r.wp_s2) begin
											pb_we = 1'b1;
											n.pvalid[r.off] = 1'b1;
											n.off = r.off + 1'b1;
										end
									end
								endcase
								n.sda_oe = n.ack;
							end
						end
						D_RACK: if (scl_fall) begin
							n.sda_oe = 1'b0;
							n.cnt = 4'h0;
							if (!r.ack) n.st = (r.kind == K_DAT) ? D_RX : D_IDLE;
							else if (r.kind == K_SEL && r.rw) begin
								// Read path never looks at write protect
								n.st = D_TX;
								n.sh = rd_byte;
								n.sda_oe = ~rd_byte[7];
							end else begin
								n.st = D_RX;
								n.slot10 = r.kind == K_DAT;
								case (r.kind)
									K_SEL: n.kind = K_AHI;
									K_AHI: n.kind = K_ALO;
									default: n.kind = K_DAT;
								endcase
							end
						end
						D_TX: begin
							if (scl_rise) n.cnt = r.cnt + 4'h1;
							if (scl_fall) begin
								if (r.cnt == `EEP_BYTE_BITS) begin
									n.sda_oe = 1'b0;
									n.st = D_MACK;
									n.addr = r.addr + 1'b1;
								end else begin
									n.sh = {r.sh[6:0], 1'b0};
									n.sda_oe = ~r.sh[6];
								end
							end
						end
						D_MACK: begin
							// High in the ack slot means the master is done
							if (scl_rise && r.sda_s2) n.st = D_IDLE;
							else if (scl_fall) begin
								n.st = D_TX;
								n.cnt = 4'h0;
								n.sh = rd_byte;
								n.sda_oe = ~rd_byte[7];
							end
						end
						default: n.sda_oe = 1'b0;
					endcase
				end
			end
		endcase
	end

	// SCL and SDA sync stages idle high so reset release makes no false start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= D_IDLE;
			r.kind <= K_SEL;
			r.scl_s1 <= 1'b1;
			r.scl_s2 <= 1'b1;
			r.scl_d <= 1'b1;
			r.sda_s1 <= 1'b1;
			r.sda_s2 <= 1'b1;
			r.sda_d <= 1'b1;
		end else r <= n;
	end

	// Page latch: a later byte at the same offset simply replaces the earlier one
	always_ff @(posedge clk) begin
		if (pb_we) pb[r.off] <= r.sh;
	end

	// Array has no reset so its contents survive a link reset
	always_ff @(posedge clk) begin
		if (mem_we) mem[mem_wa] <= pb[r.cidx];
	end

	assign link.sda_d_out = 1'b0;
	assign link.sda_d_oe = r.sda_oe;
	assign write_busy = r.st == D_BUSY;
	// Offset width fixes the page size
	logic unused_page_last;
	assign unused_page_last = &PAGE_LAST;
endmodule : eep_dev

// file: test/eep_assertions.sv
// Link watcher: ownership and timing checks on the two-wire link
module eep_assertions #(
	parameter int TW_CYC = 200 // Write cycle length in clk
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Async reset
	input wire logic scl, // Link clock
	input wire logic sda_h_oe, // Master pulls low
	input wire logic sda_d_oe, // Device pulls low
	input wire logic sda, // Resolved data line
	input wire logic write_busy // Device write cycle
);
	logic [15:0] busy_reg, busy_next, hold_reg, hold_next;
	// Run lengths of the write cycle and of each device pull
	always_comb begin
		busy_next = write_busy ? busy_reg + 16'h1 : 16'h0;
		hold_next = sda_d_oe ? hold_reg + 16'h1 : 16'h0;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 16'h0;
			hold_reg <= 16'h0;
		end else begin
			busy_reg <= busy_next;
			hold_reg <= hold_next;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	busy_quiet_a: assert property (write_busy |-> !sda_d_oe)
		else $error("device drives link during write cycle");
	busy_len_a: assert property ($fell(write_busy) |-> busy_reg == TW_CYC)
		else $error("write cycle length wrong");
	busy_cap_a: assert property (busy_reg <= TW_CYC)
		else $error("write cycle overran");
	busy_entry_a: assert property ($rose(write_busy) |-> scl && sda && !sda_h_oe)
		else $error("write cycle began without stop");
	// Device pull starts early in the low phase, so the bit is set up well before the rise
	dev_setup_a: assert property ($rose(sda_d_oe) |-> !scl [*8])
		else $error("device pull too close to clock rise");
	dev_edge_a: assert property ($changed(sda_d_oe) |-> !scl)
		else $error("device changed data with clock high");
	ack_hold_a: assert property ($fell(sda_d_oe) |-> hold_reg >= 16'd96)
		else $error("device pull shorter than one bit");
	reset_idle_a: assert property ($rose(rst_n) |-> scl && !sda_d_oe && !sda_h_oe)
		else $error("link not idle after reset");
	busy_c: cover property ($rose(write_busy));
	ack_c: cover property ($rose(sda_d_oe));
	poll_c: cover property (write_busy && $rose(scl));
endmodule : eep_assertions

// file: test/serial_eeprom_page_write_read_bench.sv
// Bench: master end and device end joined by the link, driven from the user side
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module serial_eeprom_page_write_read_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import eep_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_cur = 1'b0;
	logic wr_valid = 1'b0, write_protect_in = 1'b0, busy_seen = 1'b0, ack_seen = 1'b0;
	logic cmd_ready, wr_ready, rd_valid, done, data_nack, write_busy;
	logic [2:0] cmd_dev = 3'h5, strap = 3'h5;
	logic [7:0] cmd_len = 8'h1;
	logic [12:0] ptr;
	eep_addr_t cmd_addr = 16'h0;
	eep_byte_t wr_data = 8'h0, rd_data;
	eep_byte_t mem [8192];
	eep_byte_t rx_q [$];
	int failures = 0, total_checks = 0;
	eep_link_if link ();
	eep_host u_eep_host (.clk(clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_cur(cmd_cur), .cmd_dev(cmd_dev),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .data_nack(data_nack));
	// Short write cycle keeps the run brief
	eep_dev #(.INTERNAL_WRITE_TIME_NS(2000)) u_eep_dev (.clk(clk), .rst_n(rst_n), .link(link),
		.write_protect_in(write_protect_in), .chip_select_strap_pins(strap), .write_busy(write_busy));
	eep_assertions #(.TW_CYC(200)) u_eep_assertions (.clk(clk), .rst_n(rst_n), .scl(link.scl),
		.sda_h_oe(link.sda_h_oe), .sda_d_oe(link.sda_d_oe), .sda(link.sda), .write_busy(write_busy));
	initial forever #5 clk = ~clk;
	// Collect read bytes and note link activity
	always @(posedge clk) begin
		if (rd_valid) rx_q.push_back(rd_data);
		if (write_busy) busy_seen = 1'b1;
		if (link.sda_d_oe) ack_seen = 1'b1;
	end
	task automatic stop_test();
		if (failures == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic issue(input logic rd, input logic cur, input eep_addr_t a, input int n);
		while (cmd_ready !== 1'b1) begin @(posedge clk); #1; end
		cmd_read = rd;
		cmd_cur = cur;
		cmd_addr = a;
		cmd_len = n[7:0];
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
	endtask : issue
	// Bounded wait: a select that is never acked would retry forever
	task automatic do_cmd(input logic rd, input logic cur, input eep_addr_t a, input int n);
		int i;
		issue(rd, cur, a, n);
		for (i = 0; i < 60000 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		#1;
		`CHK("done", 1'b1, i < 60000)
	endtask : do_cmd
	task automatic feed(input eep_byte_t base, input int n);
		for (int i = 0; i < n; i++) begin
			wr_data = base + i[7:0];
			wr_valid = 1'b1;
			while (wr_ready !== 1'b1) begin @(posedge clk); #1; end
			@(posedge clk);
			#1;
		end
		wr_valid = 1'b0;
	endtask : feed
	// Offset wraps inside the row; a later byte wins
	task automatic model_wr(input eep_addr_t a, input int n, input eep_byte_t base);
		for (int i = 0; i < n; i++) mem[{a[12:5], 5'(a[4:0] + i)}] = base + i[7:0];
	endtask : model_wr
	task automatic rd_chk(input logic cur, input eep_addr_t a, input int n);
		rx_q = {};
		if (!cur) ptr = a[12:0];
		do_cmd(1'b1, cur, a, n);
		`CHK("rd_count", n, rx_q.size())
		for (int i = 0; i < n; i++) begin
			`CHK("rd_data", mem[ptr], rx_q[i])
			ptr = ptr + 13'h1;
		end
	endtask : rd_chk
	task automatic s_reset_idle();
		`CHK("cmd_ready", 1'b1, cmd_ready)
		`CHK("wr_ready", 1'b1, wr_ready)
		`CHK("scl_idle", 1'b1, link.scl)
		`CHK("busy_idle", 1'b0, write_busy)
	endtask : s_reset_idle
	// 34 bytes from offset 30: two wrap over and replace earlier ones
	task automatic s_page_wrap();
		busy_seen = 1'b0;
		feed(8'h40, 16);
		`CHK("fifo_full", 1'b0, wr_ready)
		fork
			do_cmd(1'b0, 1'b0, 16'h001e, 34);
			feed(8'h50, 18);
		join
		model_wr(16'h001e, 34, 8'h40);
		`CHK("write_nack", 1'b0, data_nack)
		`CHK("fifo_drained", 1'b1, wr_ready)
	endtask : s_page_wrap
	// Read issued during the write cycle: polled, then crosses the top address
	task automatic s_poll_read();
		rd_chk(1'b0, 16'h1fff, 3);
		`CHK("busy_seen", 1'b1, busy_seen)
	endtask : s_poll_read
	task automatic s_cur_read();
		rd_chk(1'b1, 16'h0, 2);
	endtask : s_cur_read
	// Short write inside one row; the byte below it stays erased
	task automatic s_row_write();
		fork
			do_cmd(1'b0, 1'b0, 16'h0123, 3);
			feed(8'h90, 3);
		join
		model_wr(16'h0123, 3, 8'h90);
		`CHK("row_nack", 1'b0, data_nack)
		rd_chk(1'b0, 16'h0122, 4);
	endtask : s_row_write
	task automatic s_protect();
		write_protect_in = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		fork
			do_cmd(1'b0, 1'b0, 16'h0010, 2);
			feed(8'hc0, 2);
		join
		`CHK("protect_nack", 1'b1, data_nack)
		rd_chk(1'b0, 16'h0010, 2);
		write_protect_in = 1'b0;
	endtask : s_protect
	// Wrong strap code is never acked; reset frees the master, array survives
	task automatic s_bad_select();
		ack_seen = 1'b0;
		cmd_dev = 3'h2;
		issue(1'b1, 1'b1, 16'h0, 1);
		repeat (3000) @(posedge clk);
		#1;
		`CHK("foreign_ack", 1'b0, ack_seen)
		`CHK("still_polling", 1'b0, cmd_ready)
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		cmd_dev = 3'h5;
		rd_chk(1'b0, 16'h0005, 1);
		`CHK("sda_idle", 1'b1, link.sda)
	endtask : s_bad_select
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		s_reset_idle();
		s_page_wrap();
		s_poll_read();
		s_cur_read();
		s_row_write();
		s_protect();
		s_bad_select();
		stop_test();
	end
	// Run should end near 75000 cycles
	initial begin
		#950000;
		failures++;
		stop_test();
	end
endmodule : serial_eeprom_page_write_read_bench
